// *** design/irq_priority_pending_pkg.sv ***
package irq_priority_pending_pkg;
    // ------------------------------------------------------------
    // widths
    // ------------------------------------------------------------
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;
    localparam int LANES = 4;
    localparam int BYTE_W = 8;
    localparam int PRIO_W = 3;
    localparam int PRIO_LSB = 5;
    localparam int NUM_W = 9;

    // ------------------------------------------------------------
    // register offsets (byte addresses)
    // ------------------------------------------------------------
    localparam logic [ADDR_W-1:0] PRIO_BASE_OFS = 12'h000;
    localparam logic [ADDR_W-1:0] TRIGGER_OFS = 12'h100;
    localparam logic [ADDR_W-1:0] CTRL_OFS = 12'h104;
    localparam logic [ADDR_W-1:0] ENABLE_OFS = 12'h108;
    localparam logic [ADDR_W-1:0] SETPEND_OFS = 12'h10C;
    localparam logic [ADDR_W-1:0] CLRPEND_OFS = 12'h110;
    localparam logic [ADDR_W-1:0] ACTIVE_OFS = 12'h114;

    // ------------------------------------------------------------
    // fields and reset values
    // ------------------------------------------------------------
    localparam int CTRL_ALLOW_BIT = 0;
    localparam logic [PRIO_W-1:0] PRIO_RESET = 3'h0;
    localparam logic CTRL_ALLOW_RESET = 1'b0;

    // ------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic [LANES-1:0] be;
        logic wr;
        logic rd;
        logic priv;
    } reg_req_type;

    typedef struct packed {
        logic enter;
        logic [NUM_W-1:0] enter_num;
        logic leave;
        logic [NUM_W-1:0] leave_num;
    } core_evt_type;
endpackage

// *** design/irq_priority_pending_ctrl.sv ***
// Added by the designer: the register offsets and the address-and-strobe port.
`timescale 1ns/1ps
module irq_priority_pending_ctrl
    import irq_priority_pending_pkg::*;
#(
    parameter int N_IRQ = 32
) (
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    input wire reg_req_type reg_req_i,
    output logic [DATA_W-1:0] reg_rdata_o,
    input wire logic [N_IRQ-1:0] irq_line_i,
    input wire core_evt_type core_evt_i,
    output logic irq_req_o,
    output logic [NUM_W-1:0] irq_num_o,
    output logic [PRIO_W-1:0] irq_prio_o,
    output logic [N_IRQ-1:0] pending_o,
    output logic [N_IRQ-1:0] active_o
);
    localparam int PRIO_WORDS = (N_IRQ + LANES - 1) / LANES;

    // ------------------------------------------------------------
    // decode helpers
    // ------------------------------------------------------------
    function automatic logic reg_hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] ofs);
        reg_hit = (a[ADDR_W-1:2] == ofs[ADDR_W-1:2]);
    endfunction

    function automatic logic prio_hit(input logic [ADDR_W-1:0] a, input int word);
        prio_hit = (a[ADDR_W-1:2] == (PRIO_BASE_OFS[ADDR_W-1:2] + (ADDR_W-2)'(word)));
    endfunction

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic [PRIO_W-1:0] prio_q [N_IRQ];
    logic allow_q;
    logic [N_IRQ-1:0] enable_q;
    logic [N_IRQ-1:0] pending_q;
    logic [N_IRQ-1:0] active_q;
    logic [N_IRQ-1:0] line_q;
    logic [DATA_W-1:0] rdata_q;
    logic req_q;
    logic [NUM_W-1:0] num_q;
    logic [PRIO_W-1:0] prio_out_q;

    logic wr_trig;
    logic [N_IRQ-1:0] trig_vec;
    logic [N_IRQ-1:0] setpend_vec;
    logic [N_IRQ-1:0] clrpend_vec;
    logic [DATA_W-1:0] rdata_d;
    logic req_d;
    logic [NUM_W-1:0] num_d;
    logic [PRIO_W-1:0] prio_d;

    // ------------------------------------------------------------
    // software trigger and pending writes
    // ------------------------------------------------------------
    assign wr_trig = reg_req_i.wr && reg_hit(reg_req_i.addr, TRIGGER_OFS)
                     && (reg_req_i.priv || allow_q);

    always_comb begin
        trig_vec = '0;
        for (int i = 0; i < N_IRQ; i++) begin
            if (wr_trig && reg_req_i.wdata[NUM_W-1:0] == NUM_W'(i)) begin
                trig_vec[i] = 1'b1;
            end
        end
    end

    assign setpend_vec = (reg_req_i.wr && reg_hit(reg_req_i.addr, SETPEND_OFS))
                         ? reg_req_i.wdata[N_IRQ-1:0] : '0;
    assign clrpend_vec = (reg_req_i.wr && reg_hit(reg_req_i.addr, CLRPEND_OFS))
                         ? reg_req_i.wdata[N_IRQ-1:0] : '0;

    // ------------------------------------------------------------
    // control and enable registers
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            allow_q <= CTRL_ALLOW_RESET;
        end else if (reg_req_i.wr && reg_req_i.priv && reg_hit(reg_req_i.addr, CTRL_OFS)) begin
            allow_q <= reg_req_i.wdata[CTRL_ALLOW_BIT];
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            enable_q <= '0;
        end else if (reg_req_i.wr && reg_hit(reg_req_i.addr, ENABLE_OFS)) begin
            enable_q <= reg_req_i.wdata[N_IRQ-1:0];
        end
    end

    // ------------------------------------------------------------
    // per-interrupt priority and pending/active state
    // ------------------------------------------------------------
    for (genvar i = 0; i < N_IRQ; i++) begin : g_irq
        logic enter_hit;
        logic leave_hit;
        logic hw_set;
        logic set_ev;
        logic clr_ev;

        assign enter_hit = core_evt_i.enter && core_evt_i.enter_num == NUM_W'(i);
        assign leave_hit = core_evt_i.leave && core_evt_i.leave_num == NUM_W'(i);
        assign hw_set = irq_line_i[i] && !active_q[i] && !enter_hit
                        || irq_line_i[i] && !line_q[i] && !enter_hit;
        assign set_ev = hw_set || trig_vec[i] || setpend_vec[i]
                        || leave_hit && irq_line_i[i];
        assign clr_ev = enter_hit
                        || clrpend_vec[i] && !irq_line_i[i];

        always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
            if (!rst_n_i) begin
                prio_q[i] <= PRIO_RESET;
            end else if (reg_req_i.wr && prio_hit(reg_req_i.addr, i / LANES)
                         && reg_req_i.be[i % LANES]) begin
                prio_q[i] <= reg_req_i.wdata[(i % LANES) * BYTE_W + PRIO_LSB +: PRIO_W];
            end
        end

        always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
            if (!rst_n_i) begin
                pending_q[i] <= 1'b0;
            end else if (set_ev) begin
                pending_q[i] <= 1'b1;
            end else if (clr_ev) begin
                pending_q[i] <= 1'b0;
            end
        end

        always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
            if (!rst_n_i) begin
                active_q[i] <= 1'b0;
            end else if (enter_hit) begin
                active_q[i] <= 1'b1;
            end else if (leave_hit) begin
                active_q[i] <= 1'b0;
            end
        end

        always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
            if (!rst_n_i) begin
                line_q[i] <= 1'b0;
            end else begin
                line_q[i] <= irq_line_i[i];
            end
        end
    end

    // ------------------------------------------------------------
    // arbitration
    // ------------------------------------------------------------
    always_comb begin
        req_d = 1'b0;
        num_d = '0;
        prio_d = '0;
        for (int i = 0; i < N_IRQ; i++) begin
            if (enable_q[i] && pending_q[i] && !active_q[i]) begin
                if (!req_d || prio_q[i] < prio_d) begin
                    req_d = 1'b1;
                    num_d = NUM_W'(i);
                    prio_d = prio_q[i];
                end
            end
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            req_q <= 1'b0;
            num_q <= '0;
            prio_out_q <= '0;
        end else begin
            req_q <= req_d;
            num_q <= num_d;
            prio_out_q <= prio_d;
        end
    end

    // ------------------------------------------------------------
    // read path
    // ------------------------------------------------------------
    always_comb begin
        rdata_d = '0;
        for (int w = 0; w < PRIO_WORDS; w++) begin
            if (prio_hit(reg_req_i.addr, w)) begin
                for (int j = 0; j < LANES; j++) begin
                    if (w * LANES + j < N_IRQ) begin
                        rdata_d[j * BYTE_W + PRIO_LSB +: PRIO_W] = prio_q[w * LANES + j];
                    end
                end
            end
        end
        if (reg_hit(reg_req_i.addr, CTRL_OFS)) begin
            rdata_d[CTRL_ALLOW_BIT] = allow_q;
        end
        if (reg_hit(reg_req_i.addr, ENABLE_OFS)) begin
            rdata_d = DATA_W'(enable_q);
        end
        if (reg_hit(reg_req_i.addr, SETPEND_OFS) || reg_hit(reg_req_i.addr, CLRPEND_OFS)) begin
            rdata_d = DATA_W'(pending_q);
        end
        if (reg_hit(reg_req_i.addr, ACTIVE_OFS)) begin
            rdata_d = DATA_W'(active_q);
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rdata_q <= '0;
        end else if (reg_req_i.rd) begin
            rdata_q <= rdata_d;
        end else begin
            rdata_q <= '0;
        end
    end

    assign reg_rdata_o = rdata_q;
    assign irq_req_o = req_q;
    assign irq_num_o = num_q;
    assign irq_prio_o = prio_out_q;
    assign pending_o = pending_q;
    assign active_o = active_q;
endmodule

// *** tb/irq_source_model.sv ***
`timescale 1ns/1ps
// ----
// peripheral request lines
// ----
module irq_source_model #(
    parameter int N = 32
) (
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    input wire logic [N-1:0] raise_i,
    input wire logic [N-1:0] serviced_i,
    output logic [N-1:0] line_o
);
    // level held until the handler services the peripheral
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            line_o <= '0;
        end else begin
            line_o <= (line_o | raise_i) & ~serviced_i;
        end
    end
endmodule

// *** tb/irq_priority_pending_ctrl_asserts.sv ***
`timescale 1ns/1ps
module irq_priority_pending_ctrl_asserts
    import irq_priority_pending_pkg::*;
#(
    parameter int N_IRQ = 32
) (
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    input wire reg_req_type reg_req_i,
    input wire logic [DATA_W-1:0] reg_rdata_o,
    input wire logic [N_IRQ-1:0] irq_line_i,
    input wire core_evt_type core_evt_i,
    input wire logic irq_req_o,
    input wire logic [NUM_W-1:0] irq_num_o,
    input wire logic [PRIO_W-1:0] irq_prio_o,
    input wire logic [N_IRQ-1:0] pending_o,
    input wire logic [N_IRQ-1:0] active_o
);
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!rst_n_i);
    logic [N_IRQ-1:0] ent_v;
    logic [N_IRQ-1:0] cand_v;
    logic [N_IRQ-1:0] hi_v;
    assign ent_v = core_evt_i.enter ? (N_IRQ'(1) << core_evt_i.enter_num) : '0;
    assign cand_v = pending_o & ~active_o;
    assign hi_v = irq_line_i & ~active_o & ~ent_v;
    chk_prio_low_zero: assert property (
        $past(reg_req_i.rd) && $past(reg_req_i.addr) < TRIGGER_OFS
        |-> (reg_rdata_o & 32'h1F1F1F1F) == '0) else $error("prio low bits set");
    chk_trigger_pends: assert property (
        reg_req_i.wr && reg_req_i.priv && reg_req_i.addr == TRIGGER_OFS &&
        reg_req_i.wdata[8:0] < N_IRQ |=> pending_o[$past(reg_req_i.wdata[8:0])])
        else $error("trigger lost");
    chk_enter_active: assert property (
        core_evt_i.enter |=> active_o[$past(core_evt_i.enter_num)] &&
        !pending_o[$past(core_evt_i.enter_num)]) else $error("enter wrong");
    chk_leave_sample: assert property (
        core_evt_i.leave |=> !active_o[$past(core_evt_i.leave_num)] &&
        pending_o[$past(core_evt_i.leave_num)] == $past(irq_line_i[core_evt_i.leave_num]))
        else $error("leave wrong");
    chk_level_pends: assert property (
        hi_v != '0 |=> (pending_o & $past(hi_v)) == $past(hi_v)) else $error("level lost");
    chk_edge_pends: assert property (
        irq_line_i[1] && !$past(irq_line_i[1]) |=> pending_o[1]) else $error("edge lost");
    chk_clear_held: assert property (
        reg_req_i.wr && reg_req_i.addr == CLRPEND_OFS && reg_req_i.wdata[1] &&
        (pending_o[1] || !irq_line_i[1]) |=> pending_o[1] == $past(irq_line_i[1]))
        else $error("clear wrong");
    chk_offer_valid: assert property (
        irq_req_o |-> (($past(cand_v) >> irq_num_o) & 1) != 0) else $error("bad offer");
endmodule
bind irq_priority_pending_ctrl irq_priority_pending_ctrl_asserts #(.N_IRQ(N_IRQ)) u_chk (
    .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .reg_req_i(reg_req_i),
    .reg_rdata_o(reg_rdata_o), .irq_line_i(irq_line_i), .core_evt_i(core_evt_i),
    .irq_req_o(irq_req_o), .irq_num_o(irq_num_o), .irq_prio_o(irq_prio_o),
    .pending_o(pending_o), .active_o(active_o));

// *** tb/irq_priority_pending_ctrl_tb_top.sv ***
`timescale 1ns/1ps
module irq_priority_pending_ctrl_tb_top
    import irq_priority_pending_pkg::*;
;
    logic clk_sys_i = 1'b0;
    logic rst_n_i = 1'b0;
    reg_req_type req = '0;
    core_evt_type evt = '0;
    logic [31:0] raise = '0;
    logic [31:0] svc = '0;
    logic [31:0] line;
    logic [31:0] rdata;
    logic [31:0] pend;
    logic [31:0] act;
    logic irq_req;
    logic [8:0] num;
    logic [2:0] prio;
    int err_count = 0;
    int check_count = 0;
    int cyc = 0;
    always #4 clk_sys_i = ~clk_sys_i;
    irq_source_model #(.N(32)) u_irq_source_model (.clk_sys_i(clk_sys_i),
        .rst_n_i(rst_n_i), .raise_i(raise), .serviced_i(svc), .line_o(line));
    irq_priority_pending_ctrl #(.N_IRQ(32)) u_irq_priority_pending_ctrl (
        .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .reg_req_i(req), .reg_rdata_o(rdata),
        .irq_line_i(line), .core_evt_i(evt), .irq_req_o(irq_req), .irq_num_o(num),
        .irq_prio_o(prio), .pending_o(pend), .active_o(act));
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        check_count++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] b = 4'hF,
        input logic p = 1'b1);
        @(posedge clk_sys_i);
        req <= '{addr: a, wdata: d, be: b, wr: 1'b1, rd: 1'b0, priv: p};
        @(posedge clk_sys_i);
        req.wr <= 1'b0;
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] exp);
        @(posedge clk_sys_i);
        req <= '{addr: a, wdata: 32'h0, be: 4'h0, wr: 1'b0, rd: 1'b1, priv: 1'b1};
        @(posedge clk_sys_i);
        req.rd <= 1'b0;
        #1 chk(rdata, exp);
    endtask
    task automatic cy(input int n);
        repeat (n) @(posedge clk_sys_i);
        #1;
    endtask
    task automatic ev(input logic e);
        @(posedge clk_sys_i);
        evt <= '{enter: e, enter_num: 9'h001, leave: !e, leave_num: 9'h001};
        @(posedge clk_sys_i);
        evt <= '0;
    endtask
    task automatic ln(input logic up);
        @(posedge clk_sys_i);
        if (up) raise <= 32'h2;
        else svc <= 32'h2;
        @(posedge clk_sys_i);
        raise <= '0;
        svc <= '0;
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    always @(posedge clk_sys_i) begin
        cyc++;
        if (cyc == 3000) begin
            err_count++;
            tally_and_finish();
        end
    end
    initial begin
        repeat (4) @(posedge clk_sys_i);
        rst_n_i <= 1'b1;
        rd(PRIO_BASE_OFS, 32'h0);
        for (int j = 0; j < 4; j++) begin
            wr(12'h004, 32'hFFFFFFFF, 4'(1 << j));
            rd(12'h004, 32'hE0E0E0E0 >> (8 * (3 - j)));
        end
        wr(12'h004, 32'h1234ABCD);
        rd(12'h004, 32'h0020A0C0);
        $display("priority bytes done");
        wr(PRIO_BASE_OFS, 32'h20600000);
        wr(12'h004, 32'h00002000);
        wr(ENABLE_OFS, 32'h2C);
        wr(SETPEND_OFS, 32'h3C);
        cy(2);
        chk({pend, irq_req, num, prio}, {32'h3C, 1'b1, 9'h003, 3'h1});
        wr(CLRPEND_OFS, 32'h8);
        cy(2);
        chk({irq_req, num, prio}, {1'b1, 9'h005, 3'h1});
        wr(CLRPEND_OFS, 32'h20);
        cy(2);
        chk({irq_req, num, prio}, {1'b1, 9'h002, 3'h3});
        wr(CLRPEND_OFS, 32'hFFFFFFFF);
        cy(2);
        chk({irq_req, pend}, 33'h0);
        $display("arbitration done");
        wr(TRIGGER_OFS, 32'h7, 4'hF, 1'b0);
        wr(CTRL_OFS, 32'h1, 4'hF, 1'b0);
        wr(TRIGGER_OFS, 32'h7, 4'hF, 1'b0);
        cy(0);
        chk(pend, 32'h0);
        wr(CTRL_OFS, 32'h1);
        wr(TRIGGER_OFS, 32'hFFFFFE07, 4'hF, 1'b0);
        wr(TRIGGER_OFS, 32'h1FF);
        wr(TRIGGER_OFS, 32'h3);
        cy(0);
        chk(pend, 32'h88);
        wr(CLRPEND_OFS, 32'h88);
        $display("trigger done");
        wr(ENABLE_OFS, 32'h2);
        ln(1'b1);
        cy(1);
        chk(pend, 32'h2);
        ev(1'b1);
        cy(0);
        chk({pend, act}, {32'h0, 32'h2});
        rd(ACTIVE_OFS, 32'h2);
        ev(1'b0);
        cy(0);
        chk({pend, act}, {32'h2, 32'h0});
        wr(CLRPEND_OFS, 32'h2);
        cy(0);
        chk(pend, 32'h2);
        ev(1'b1);
        ln(1'b0);
        ev(1'b0);
        cy(0);
        chk({pend, act}, 64'h0);
        $display("level flow done");
        tally_and_finish();
    end
endmodule
